// file: test_trigger_holdoff_width_qualifier.sv
`timescale 1ns/1ps
`default_nettype none

module test_trigger_holdoff_width_qualifier;
    import twq_pkg::*;
    localparam logic [31:0] MAX_C = 32'h0000_0040;
    localparam logic [31:0] NOCHK = 32'hffff_ffff;
    typedef struct {
        logic qual; logic fall; twq_mode_t mode; logic wint; logic zero;
        logic [31:0] val; int hi; int lo; int ntr; logic [31:0] xval;
    } twq_row_t;

    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    logic        ref_clk_i, reset_n_i, ce_i, comp_i, slope_fall_i;
    logic        qual_en_i, mode_load_i, width_interval_i;
    logic        width_type_load_i, value_load_i, zero_i, edit_begin_i;
    logic        cancel_i, save_i, recall_i, delay_load_i, delay_zero_i;
    logic        trig_o, holdoff_busy_o, width_interval_o;
    logic [31:0] value_i, delay_i, value_o, delay_o;
    twq_mode_t   mode_sel_i, mode_o;
    int          n_mismatch, check_count, n_trig, n_base;
    twq_row_t    r;
    twq_row_t    rows [14] = '{
      '{0,0,TWQ_HOLD_TIME,0,0,32'h0f,5,5,6,32'h0f},
      '{0,1,TWQ_HOLD_TIME,0,0,32'h0f,5,5,6,32'h0f},
      '{1,0,TWQ_HOLD_TIME,0,0,32'h0f,5,5,3,32'h0f},
      '{1,0,TWQ_HOLD_TIME,0,0,32'h64,5,5,1,32'h40},
      '{1,0,TWQ_HOLD_TIME,0,1,32'h0f,5,5,6,32'h01},
      '{1,0,TWQ_HOLD_TIME,1,0,32'h0f,5,5,3,32'h0f},
      '{1,0,TWQ_HOLD_EVENTS,0,0,32'h02,5,5,2,32'h02},
      '{1,0,TWQ_HOLD_EVENTS,0,1,32'h02,5,5,6,32'h00},
      '{1,0,TWQ_WIDTH_LT,0,0,32'h05,3,7,6,32'h05},
      '{1,0,TWQ_WIDTH_LT,0,0,32'h05,8,4,0,32'h05},
      '{1,0,TWQ_WIDTH_GT,0,0,32'h05,8,4,6,32'h05},
      '{1,0,TWQ_WIDTH_GT,0,0,32'h05,3,7,0,32'h05},
      '{1,0,TWQ_WIDTH_GT,0,1,32'h05,3,7,6,32'h01},
      '{1,0,TWQ_WIDTH_LT,1,0,32'h05,2,8,0,32'h05}};

    twq_src_model src (.ref_clk_i(ref_clk_i), .comp_o(comp_i));

    twq_core #(.MAX_CYC(MAX_C)) dut (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
        .comp_i(comp_i), .slope_fall_i(slope_fall_i),
        .qual_en_i(qual_en_i), .mode_sel_i(mode_sel_i),
        .mode_load_i(mode_load_i), .width_interval_i(width_interval_i),
        .width_type_load_i(width_type_load_i), .value_i(value_i),
        .value_load_i(value_load_i), .zero_i(zero_i),
        .edit_begin_i(edit_begin_i), .cancel_i(cancel_i), .save_i(save_i),
        .recall_i(recall_i), .delay_i(delay_i), .delay_load_i(delay_load_i),
        .delay_zero_i(delay_zero_i), .trig_o(trig_o),
        .holdoff_busy_o(holdoff_busy_o), .mode_o(mode_o),
        .width_interval_o(width_interval_o), .value_o(value_o),
        .delay_o(delay_o));

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        if (trig_o === 1'b1) n_trig++;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) begin @(posedge ref_clk_i); #1; end
    endtask

    task automatic clr;
        {mode_load_i, width_type_load_i, value_load_i, zero_i} = 4'h0;
        {edit_begin_i, cancel_i, save_i, recall_i} = 4'h0;
        {delay_load_i, delay_zero_i} = 2'h0;
    endtask

    task automatic fire;
        step(1);
        clr();
        step(1);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk_rst;
        check(value_o, ZERO_HOLD_CYC);
        check({30'h0, mode_o}, {30'h0, TWQ_HOLD_TIME});
        check({31'h0, width_interval_o}, 32'h0);
        check(delay_o, DELAY_RST);
        check({30'h0, trig_o, holdoff_busy_o}, 32'h0);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        n_mismatch++;
        final_report();
    end

    initial begin
        {reset_n_i, ce_i, slope_fall_i, qual_en_i, width_interval_i} = 5'h0a;
        mode_sel_i = TWQ_HOLD_TIME;
        {value_i, delay_i} = '0;
        clr();
        step(16);
        reset_n_i = 1'b1;
        step(1);
        chk_rst();
        foreach (rows[i]) begin
            r = rows[i];
            {qual_en_i, slope_fall_i, width_interval_i} = {r.qual, r.fall, r.wint};
            mode_sel_i = r.mode;
            {value_i, zero_i} = {r.val, r.zero};
            {mode_load_i, width_type_load_i, value_load_i} = 3'h7;
            fire();
            src.set_idle(r.fall);
            step(10);
            if (r.xval !== NOCHK) check(value_o, r.xval);
            check({30'h0, mode_o}, {30'h0, r.mode});
            n_base = n_trig;
            repeat (6) src.pulse(r.hi, r.lo);
            step(30);
            check(n_trig - n_base, r.ntr);
        end
        {edit_begin_i, value_i} = {1'b1, 32'h05};
        fire();
        {value_load_i, value_i} = {1'b1, 32'h09};
        fire();
        check(value_o, 32'h09);
        cancel_i = 1'b1;
        fire();
        check(value_o, 32'h05);
        save_i = 1'b1;
        fire();
        {value_load_i, mode_load_i, value_i} = {2'h3, 32'h0b};
        mode_sel_i = TWQ_WIDTH_GT;
        fire();
        recall_i = 1'b1;
        fire();
        check({29'h0, width_interval_o, mode_o}, 32'h6);
        qual_en_i = 1'b0;
        step(5);
        qual_en_i = 1'b1;
        step(2);
        check(value_o, 32'h05);
        {mode_load_i, value_load_i, value_i} = {2'h3, 32'h0f};
        mode_sel_i = TWQ_HOLD_TIME;
        fire();
        src.pulse(2, 1);
        check({30'h0, trig_o, holdoff_busy_o}, 32'h3);
        step(20);
        check({31'h0, holdoff_busy_o}, 32'h0);
        ce_i = 1'b0;
        {value_load_i, value_i} = {1'b1, 32'h21};
        fire();
        ce_i = 1'b1;
        check(value_o, 32'h0f);
        zero_i = 1'b1;
        fire();
        check(value_o, ZERO_HOLD_CYC);
        {delay_load_i, delay_i} = {1'b1, 32'h07};
        fire();
        check(delay_o, 32'h07);
        {delay_load_i, delay_zero_i, delay_i} = {2'h3, 32'h09};
        fire();
        check(delay_o, 32'h00);
        reset_n_i = 1'b0;
        step(2);
        reset_n_i = 1'b1;
        step(1);
        chk_rst();
        final_report();
    end
endmodule

`default_nettype wire

// file: twq_cfg.sv
`timescale 1ns/1ps
`default_nettype none

module twq_cfg #(
    parameter logic [31:0] MAX_CYC = 32'(twq_pkg::TIME_MAX_CYC)
) (
    // Clock and reset
    input  wire logic                       ref_clk_i,
    input  wire logic                       reset_n_i,
    input  wire logic                       ce_i,
    // Settings
    input  wire twq_pkg::twq_mode_t         mode_sel_i,
    input  wire logic                       mode_load_i,
    input  wire logic                       width_interval_i,
    input  wire logic                       width_type_load_i,
    input  wire logic [twq_pkg::VAL_W-1:0]  value_i,
    input  wire logic                       value_load_i,
    input  wire logic                       zero_i,
    // Edit session and setup store
    input  wire logic                       edit_begin_i,
    input  wire logic                       cancel_i,
    input  wire logic                       save_i,
    input  wire logic                       recall_i,
    // Active configuration
    output twq_pkg::twq_cfg_t               cfg_o
);
    import twq_pkg::*;

    twq_cfg_t           snap;
    twq_cfg_t           saved;
    logic [VAL_W-1:0]   lo;
    logic [VAL_W-1:0]   hi;
    logic [VAL_W-1:0]   zval;
    twq_mode_t          next_mode;

    // ------------------------------------------------------------
    // Range and minimum of the selection being loaded, else of the active one
    // ------------------------------------------------------------
    always_comb begin
        next_mode = mode_load_i ? mode_sel_i : cfg_o.mode;
        unique case (next_mode)
            TWQ_HOLD_TIME: begin
                lo   = HOLD_MIN_CYC;
                hi   = MAX_CYC;
                zval = ZERO_HOLD_CYC;
            end
            TWQ_HOLD_EVENTS: begin
                lo   = EVT_MIN;
                hi   = EVT_MAX;
                zval = '0;
            end
            TWQ_WIDTH_LT, TWQ_WIDTH_GT: begin
                lo   = WIDTH_MIN_CYC;
                hi   = MAX_CYC;
                zval = WIDTH_MIN_CYC;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Active configuration
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            cfg_o <= CFG_RST;
        end else if (ce_i) begin
            if (recall_i) begin
                cfg_o <= saved;
            end else if (cancel_i) begin
                cfg_o <= snap;
            end else begin
                if (mode_load_i) begin
                    cfg_o.mode <= mode_sel_i;
                end
                if (width_type_load_i) begin
                    cfg_o.width_interval <= width_interval_i;
                end
                if (zero_i) begin
                    cfg_o.value <= zval;
                end else if (value_load_i) begin
                    if (value_i < lo) begin
                        cfg_o.value <= lo;
                    end else if (value_i > hi) begin
                        cfg_o.value <= hi;
                    end else begin
                        cfg_o.value <= value_i;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Edit snapshot and stored setup
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            snap <= CFG_RST;
        end else if (ce_i && edit_begin_i) begin
            snap <= cfg_o;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            saved <= CFG_RST;
        end else if (ce_i && save_i) begin
            saved <= cfg_o;
        end
    end

endmodule

`default_nettype wire

// file: twq_core.sv
// What this block does
// - Enable input picks qualified path or plain edge trigger path.
// - Four exclusive selections share one adjustable value.
// - Dedicated command forces the trigger delay to zero.
// - Zero in hold-off gives minimum: 12.5 ns time, zero events.
// - Time hold-off 25 ns to 20 s suppresses triggers until elapsed.
// - Event hold-off skips 1 to one billion events before triggering.
// - Zeroed event hold-off still keeps 12.5 ns between triggers.
// - Zero in width modes sets the reference to its mode minimum.
// - Width-less fires on closing edge of pulse narrower than reference.
// - Width-greater fires on closing edge of pulse wider than reference.
// - Pulse or interval width type matters only in width modes.
// - Width is counted in 100 ns clock steps, so it is exact only to within 100 ns.
// - Qualified configuration is kept while the path is disabled.
// - Cancel restores the configuration held when editing began.
// - One saved setup holds the configuration; recall restores it.
`timescale 1ns/1ps
`default_nettype none

module twq_core #(
    parameter logic [31:0] MAX_CYC = 32'(twq_pkg::TIME_MAX_CYC)
) (
    // Clock, reset, enable
    input  wire logic                       ref_clk_i,
    input  wire logic                       reset_n_i,
    input  wire logic                       ce_i,
    // Comparator of the source channel
    input  wire logic                       comp_i,
    input  wire logic                       slope_fall_i,
    // Path select
    input  wire logic                       qual_en_i,
    // Qualification settings
    input  wire twq_pkg::twq_mode_t         mode_sel_i,
    input  wire logic                       mode_load_i,
    input  wire logic                       width_interval_i,
    input  wire logic                       width_type_load_i,
    input  wire logic [twq_pkg::VAL_W-1:0]  value_i,
    input  wire logic                       value_load_i,
    input  wire logic                       zero_i,
    // Edit session and setup store
    input  wire logic                       edit_begin_i,
    input  wire logic                       cancel_i,
    input  wire logic                       save_i,
    input  wire logic                       recall_i,
    // Trigger delay
    input  wire logic [twq_pkg::VAL_W-1:0]  delay_i,
    input  wire logic                       delay_load_i,
    input  wire logic                       delay_zero_i,
    // Outputs
    output logic                            trig_o,
    output logic                            holdoff_busy_o,
    output twq_pkg::twq_mode_t              mode_o,
    output logic                            width_interval_o,
    output logic [twq_pkg::VAL_W-1:0]       value_o,
    output logic [twq_pkg::VAL_W-1:0]       delay_o
);
    import twq_pkg::*;

    twq_cfg_t           cfg;
    logic               comp_s;
    logic               comp_d;
    logic               rise;
    logic               fall;
    logic               lead_edge;
    logic               close_edge;
    logic               meas_end;
    logic               in_meas;
    logic [VAL_W-1:0]   w_cnt;
    logic [VAL_W-1:0]   ho_cnt;
    logic [VAL_W-1:0]   ev_cnt;
    logic [VAL_W-1:0]   hold_cyc;
    logic [VAL_W-1:0]   ref_cyc;
    logic               ho_ready;
    logic               ev_done;
    logic               width_hit;
    logic               fire;
    logic               is_width;

    // ------------------------------------------------------------
    // Input capture and configuration
    // ------------------------------------------------------------
    twq_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .async_i   (comp_i),
        .sync_o    (comp_s)
    );

    twq_cfg #(
        .MAX_CYC (MAX_CYC)
    ) u_cfg (
        .ref_clk_i         (ref_clk_i),
        .reset_n_i         (reset_n_i),
        .ce_i              (ce_i),
        .mode_sel_i        (mode_sel_i),
        .mode_load_i       (mode_load_i),
        .width_interval_i  (width_interval_i),
        .width_type_load_i (width_type_load_i),
        .value_i           (value_i),
        .value_load_i      (value_load_i),
        .zero_i            (zero_i),
        .edit_begin_i      (edit_begin_i),
        .cancel_i          (cancel_i),
        .save_i            (save_i),
        .recall_i          (recall_i),
        .cfg_o             (cfg)
    );

    assign mode_o           = cfg.mode;
    assign width_interval_o = cfg.width_interval;
    assign value_o          = cfg.value;

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            comp_d <= 1'b0;
        end else if (ce_i) begin
            comp_d <= comp_s;
        end
    end

    assign rise       = comp_s & ~comp_d;
    assign fall       = ~comp_s & comp_d;
    assign lead_edge  = slope_fall_i ? fall : rise;
    assign close_edge = slope_fall_i ? rise : fall;

    // ------------------------------------------------------------
    // Qualification decision
    // ------------------------------------------------------------
    assign is_width = (cfg.mode == TWQ_WIDTH_LT) ||
                      (cfg.mode == TWQ_WIDTH_GT);
    // Interval width ends at the next leading edge
    assign meas_end = (is_width && cfg.width_interval) ?
                      lead_edge : close_edge;

    assign hold_cyc = (cfg.value < ZERO_HOLD_CYC) ?
                      ZERO_HOLD_CYC : cfg.value;
    assign ref_cyc  = (cfg.value < WIDTH_MIN_CYC) ?
                      WIDTH_MIN_CYC : cfg.value;
    assign ho_ready = (ho_cnt == '0);
    assign ev_done  = (ev_cnt >= cfg.value);

    always_comb begin
        width_hit = 1'b0;
        if (meas_end && in_meas) begin
            if (cfg.mode == TWQ_WIDTH_LT) begin
                width_hit = (w_cnt < ref_cyc);
            end else begin
                width_hit = (w_cnt > ref_cyc);
            end
        end
    end

    always_comb begin
        if (!qual_en_i) begin
            fire = lead_edge;
        end else begin
            unique case (cfg.mode)
                TWQ_HOLD_TIME:   fire = lead_edge && ho_ready;
                TWQ_HOLD_EVENTS: fire = lead_edge && ho_ready
                                        && ev_done;
                TWQ_WIDTH_LT,
                TWQ_WIDTH_GT:    fire = width_hit;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Hold-off timer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            ho_cnt <= '0;
        end else if (ce_i) begin
            if (!qual_en_i || is_width) begin
                ho_cnt <= '0;
            end else if (fire) begin
                if (cfg.mode == TWQ_HOLD_TIME) begin
                    ho_cnt <= hold_cyc - 32'h0000_0001;
                end else begin
                    ho_cnt <= ZERO_HOLD_CYC - 32'h0000_0001;
                end
            end else if (!ho_ready) begin
                ho_cnt <= ho_cnt - 32'h0000_0001;
            end
        end
    end

    assign holdoff_busy_o = !ho_ready;

    // ------------------------------------------------------------
    // Event counter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            ev_cnt <= '0;
        end else if (ce_i) begin
            if (!qual_en_i || cfg.mode != TWQ_HOLD_EVENTS) begin
                ev_cnt <= '0;
            end else if (fire) begin
                ev_cnt <= '0;
            end else if (lead_edge && ho_ready) begin
                ev_cnt <= ev_cnt + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Width measurement, one clock of resolution
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            in_meas <= 1'b0;
            w_cnt   <= '0;
        end else if (ce_i) begin
            if (!qual_en_i || !is_width) begin
                in_meas <= 1'b0;
                w_cnt   <= '0;
            end else if (lead_edge) begin
                in_meas <= 1'b1;
                w_cnt   <= 32'h0000_0001;
            end else if (meas_end) begin
                in_meas <= 1'b0;
            end else if (in_meas && w_cnt != '1) begin
                w_cnt <= w_cnt + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Trigger output and delay setting
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            trig_o <= 1'b0;
        end else if (ce_i) begin
            trig_o <= fire;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            delay_o <= DELAY_RST;
        end else if (ce_i) begin
            if (delay_zero_i) begin
                delay_o <= '0;
            end else if (delay_load_i) begin
                delay_o <= delay_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    std_path_a: assert property (
        ce_i && !qual_en_i && lead_edge |=> trig_o)
        else $error("plain edge did not trigger");

    holdoff_block_a: assert property (
        ce_i && qual_en_i && cfg.mode == TWQ_HOLD_TIME && lead_edge
        && !ho_ready |=> !trig_o)
        else $error("trigger inside time hold-off");

    event_skip_a: assert property (
        ce_i && qual_en_i && cfg.mode == TWQ_HOLD_EVENTS && lead_edge
        && ev_cnt < cfg.value |=> !trig_o)
        else $error("event hold-off not honoured");

    delay_zero_a: assert property (
        ce_i && delay_zero_i |=> delay_o == '0)
        else $error("delay not zeroed");

    zero_time_a: assert property (
        ce_i && zero_i && !recall_i && !cancel_i && !mode_load_i
        && cfg.mode == TWQ_HOLD_TIME |=> value_o == ZERO_HOLD_CYC)
        else $error("time hold-off zero wrong");

    width_less_a: assert property (
        ce_i && qual_en_i && cfg.mode == TWQ_WIDTH_LT && in_meas
        && meas_end && w_cnt >= ref_cyc |=> !trig_o)
        else $error("wide pulse fired width-less");

    width_more_a: assert property (
        ce_i && qual_en_i && cfg.mode == TWQ_WIDTH_GT && in_meas
        && meas_end && w_cnt > ref_cyc |=> trig_o)
        else $error("wide pulse missed width-greater");

    cfg_retain_a: assert property (
        ce_i && !qual_en_i && !mode_load_i && !value_load_i && !zero_i
        && !cancel_i && !recall_i && !width_type_load_i
        |=> $stable(value_o) && $stable(mode_o))
        else $error("configuration changed while disabled");

    restart_a: assert property (
        ce_i && qual_en_i && cfg.mode == TWQ_HOLD_TIME && fire
        && hold_cyc > 32'h0000_0001 |=> !ho_ready)
        else $error("hold-off not restarted");

    cov_time_c:  cover property (qual_en_i && cfg.mode == TWQ_HOLD_TIME
                                 && trig_o ##[1:20] trig_o);
    cov_event_c: cover property (qual_en_i
                                 && cfg.mode == TWQ_HOLD_EVENTS && trig_o);
    cov_width_c: cover property (qual_en_i && is_width && width_hit);
    cov_cancel_c: cover property (edit_begin_i ##[1:10] cancel_i);

endmodule

`default_nettype wire

// file: twq_pkg.sv
`default_nettype none

package twq_pkg;

    // ------------------------------------------------------------
    // Widths and qualification modes
    // ------------------------------------------------------------
    localparam int VAL_W = 32;

    typedef enum logic [1:0] {
        TWQ_HOLD_TIME,
        TWQ_HOLD_EVENTS,
        TWQ_WIDTH_LT,
        TWQ_WIDTH_GT
    } twq_mode_t;

    typedef struct packed {
        twq_mode_t          mode;
        logic               width_interval;
        logic [VAL_W-1:0]   value;
    } twq_cfg_t;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint unsigned CLK_HZ        = 64'd10_000_000;
    localparam longint unsigned CLK_PERIOD_PS = 64'd1_000_000_000_000 / CLK_HZ;

    localparam longint unsigned ZERO_HOLD_PS  = 64'd12_500;
    localparam longint unsigned HOLD_MIN_PS   = 64'd25_000;
    localparam longint unsigned WIDTH_MIN_PS  = 64'd2_500;
    localparam longint unsigned TIME_MAX_S    = 64'd20;

    function automatic logic [VAL_W-1:0] ceil_cyc(longint unsigned ps);
        longint unsigned c;
        c = (ps + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS;
        ceil_cyc = (c < 64'd1) ? 32'h0000_0001 : c[VAL_W-1:0];
    endfunction

    localparam logic [VAL_W-1:0] ZERO_HOLD_CYC = ceil_cyc(ZERO_HOLD_PS);
    localparam logic [VAL_W-1:0] HOLD_MIN_CYC  = ceil_cyc(HOLD_MIN_PS);
    localparam logic [VAL_W-1:0] WIDTH_MIN_CYC = ceil_cyc(WIDTH_MIN_PS);
    localparam longint unsigned  TIME_MAX_CYC  = TIME_MAX_S * CLK_HZ;

    // ------------------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------------------
    localparam logic [VAL_W-1:0] EVT_MIN   = 32'h0000_0001;
    localparam logic [VAL_W-1:0] EVT_MAX   = 32'h3b9a_ca00;
    localparam logic [VAL_W-1:0] DELAY_RST = 32'h0000_0000;

    localparam twq_cfg_t CFG_RST = '{
        mode:           TWQ_HOLD_TIME,
        width_interval: 1'b0,
        value:          ZERO_HOLD_CYC
    };

endpackage

`default_nettype wire

// file: twq_src_model.sv
`timescale 1ns/1ps
`default_nettype none

module twq_src_model (
    // Clock
    input  wire logic ref_clk_i,
    // Comparator level of the source channel
    output logic      comp_o
);
    // ------------------------------------------------------------
    // Pulse generation
    // ------------------------------------------------------------
    logic idle_lvl;

    initial begin
        idle_lvl = 1'b0;
        comp_o   = 1'b0;
    end

    task automatic set_idle(input logic lvl);
        idle_lvl = lvl;
        comp_o   = lvl;
    endtask

    // Leading edge leaves the idle level, closing edge returns to it
    task automatic pulse(input int hi, input int lo);
        comp_o = ~idle_lvl;
        repeat (hi) @(posedge ref_clk_i);
        #1 comp_o = idle_lvl;
        repeat (lo) @(posedge ref_clk_i);
        #1;
    endtask
endmodule

`default_nettype wire

// file: twq_sync.sv
`timescale 1ns/1ps
`default_nettype none

module twq_sync (
    // Clock and reset
    input  wire logic   ref_clk_i,
    input  wire logic   reset_n_i,
    input  wire logic   ce_i,
    // Level in and out
    input  wire logic   async_i,
    output logic        sync_o
);

    logic meta;

    // ------------------------------------------------------------
    // Two stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            meta   <= 1'b0;
            sync_o <= 1'b0;
        end else if (ce_i) begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule

`default_nettype wire
